// ===== inc/irq_ctrl_pkg.sv
// package: register map, fields, reset values and timing for irq control
package irq_ctrl_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // register word addresses (byte address = 4 * index)
  localparam logic [ADDR_W-1:0] IDX_IRQ_CONTROL  = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_FLAG_ONE     = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_FLAG_TWO     = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_FLAG_THREE   = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_ENABLE_ONE   = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_ENABLE_TWO   = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_ENABLE_THREE = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_OPTION       = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_CORE_STATUS  = 4'h8;
  // irq_control_reg fields
  localparam int BIT_GLOBAL_EN   = 7;
  localparam int BIT_GROUP_EN    = 6;
  localparam int BIT_TIMER_EN    = 5;
  localparam int BIT_EXT_EN      = 4;
  localparam int BIT_CHANGE_EN   = 3;
  localparam int BIT_TIMER_FLAG  = 2;
  localparam int BIT_EXT_FLAG    = 1;
  localparam int BIT_CHANGE_FLAG = 0;
  // option register field
  localparam int BIT_EDGE_SELECT = 6;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_FLAGS   = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic       RST_EDGE    = 1'b1;
  // vector and instruction cycle phases
  localparam logic [14:0] IRQ_VECTOR  = 15'h0004;
  localparam int          PHASES      = 4;
  localparam logic [1:0]  PHASE_ONE   = 2'h0;
  localparam logic [1:0]  PHASE_FOUR  = 2'h3;
  // entry sequence length in instruction cycles before vector fetch
  localparam logic [1:0]  ENTRY_CYCLES = 2'h2;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_FLUSH = 2'b01,
    ST_ENTRY = 2'b10,
    ST_WAKE  = 2'b11
  } seq_state_type;
endpackage

// ===== rtl/pin_edge_catch.sv
// pin synchroniser and edge detector for the external interrupt pin
`timescale 1ns/100ps
`default_nettype none
module pin_edge_catch
  (
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    input  wire logic pin_i,
    input  wire logic rising_i,
    output logic      edge_o
  );
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // rising or falling chosen by edge select
  assign edge_o = rising_i ? (sync_reg & ~last_reg) : (~sync_reg & last_reg);
endmodule
`default_nettype wire

// ===== rtl/cpu_interrupt_control.sv
// interrupt control: flags, enables, request, entry and return sequencing
// Contract
// (RULE_01) any reset clears all enables; nothing vectors until re-enabled
// (RULE_02) an event vectors only with global enable and its own enable set
// (RULE_03) peripheral events also need the peripheral group enable
// (RULE_04) flags set on their event regardless of any enable bit
// (RULE_05) control and peripheral flag registers hold one flag per source
// (RULE_06) entry: flush, clear global enable, push pc, shadow, load 0004h
// (RULE_07) firmware clears pending flags before returning or re-enters at once
// (RULE_08) firmware finds the source by polling flags; one shared vector
// (RULE_09) with global enable clear flags still set; serviced once it is set
// (RULE_10) return pops address, restores shadow context and sets global enable
// (RULE_11) synchronous events reach the vector in three or four cycles
// (RULE_12) asynchronous events reach the vector in three to five cycles
// (RULE_13) latency is the same for one- and two-cycle instructions
// (RULE_14) external pin flag is sampled once per cycle at phase one
// (RULE_15) external pin flag may be set from phase four through phase one
// (RULE_16) only sources running without the system clock may wake from sleep
// (RULE_17) firmware sets wake source enables before executing sleep
// (RULE_18) on wake vector if global enable set, else continue after sleep
// (RULE_19) the instruction after sleep always runs before any branch
// (RULE_20) pin flag sets on rising edge if edge select is one, else falling
// (RULE_21) shadow covers w, status less timeout/powerdown, bank, fsr, pclath
// (RULE_22) global enable is bit 7, group enable bit 6, both reset to zero
// (RULE_23) request is or of flag and enable, group gated, all global gated
`timescale 1ns/100ps
`default_nettype none
module cpu_interrupt_control
  #(
    parameter int PERIPH_W = 8
  )
  (
    input  wire logic                            clk_sys_i,
    input  wire logic                            reset_n_i,
    // avalon-mm slave, word addressed
    input  wire logic [irq_ctrl_pkg::ADDR_W-1:0] avs_address_i,
    input  wire logic                            avs_read_i,
    input  wire logic                            avs_write_i,
    input  wire logic [3:0]                      avs_byteenable_i,
    input  wire logic [irq_ctrl_pkg::DATA_W-1:0] avs_writedata_i,
    output logic [irq_ctrl_pkg::DATA_W-1:0]      avs_readdata_o,
    output logic                                 avs_waitrequest_o,
    output logic [1:0]                           avs_response_o,
    // event sources
    input  wire logic                            ext_pin_i,
    input  wire logic                            timer_event_i,
    input  wire logic                            change_event_i,
    input  wire logic [PERIPH_W-1:0]             periph_event_one_i,
    input  wire logic [PERIPH_W-1:0]             periph_event_two_i,
    input  wire logic [PERIPH_W-1:0]             periph_event_three_i,
    input  wire logic [PERIPH_W-1:0]             wake_capable_one_i,
    input  wire logic [PERIPH_W-1:0]             wake_capable_two_i,
    input  wire logic [PERIPH_W-1:0]             wake_capable_three_i,
    // core sequencer
    input  wire logic                            cycle_start_i,
    input  wire logic                            sleeping_i,
    input  wire logic                            return_from_irq_i,
    input  wire logic                            instr_done_i,
    output logic                                 irq_request_o,
    output logic                                 flush_o,
    output logic                                 push_pc_o,
    output logic                                 shadow_save_o,
    output logic                                 shadow_restore_o,
    output logic                                 pop_pc_o,
    output logic                                 load_vector_o,
    output logic [14:0]                          vector_o,
    output logic                                 wake_o,
    output logic [1:0]                           phase_o
  );
  import irq_ctrl_pkg::*;

  logic [7:0]          control_reg;
  logic [PERIPH_W-1:0] flag_one_reg;
  logic [PERIPH_W-1:0] flag_two_reg;
  logic [PERIPH_W-1:0] flag_three_reg;
  logic [PERIPH_W-1:0] enable_one_reg;
  logic [PERIPH_W-1:0] enable_two_reg;
  logic [PERIPH_W-1:0] enable_three_reg;
  logic                edge_select_reg;
  logic [1:0]          phase_reg;
  logic                ext_pending_reg;
  logic                req_sampled_reg;
  logic [1:0]          entry_cnt_reg;
  logic                wake_reg;
  logic [DATA_W-1:0]   readdata_reg;
  logic                ack_reg;
  logic [1:0]          resp_reg;
  seq_state_type       state_reg;

  logic                ext_edge;
  logic                access;
  logic                wr_en;
  logic                wr_low;
  logic                mapped;
  logic                periph_any;
  logic                core_any;
  logic                wake_any;
  logic                request;
  logic                entering;

  function automatic logic [PERIPH_W-1:0] flag_next
    (
      input logic [PERIPH_W-1:0] cur,
      input logic [PERIPH_W-1:0] evt,
      input logic                wr,
      input logic [PERIPH_W-1:0] wdata
    );
    // a write only clears/sets; a same-cycle event still sets
    flag_next = (wr ? wdata : cur) | evt;
  endfunction

  function automatic logic [DATA_W-1:0] widen
    (
      input logic [PERIPH_W-1:0] v
    );
    widen = DATA_W'(v);
  endfunction

  pin_edge_catch u_pin_edge_catch
  (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .pin_i     (ext_pin_i),
    .rising_i  (edge_select_reg), // RULE_20
    .edge_o    (ext_edge)
  );

  // avalon slave: one wait cycle, answer on the second cycle
  assign access = (avs_read_i | avs_write_i) & ~ack_reg;
  assign wr_en  = avs_write_i & ack_reg;
  assign wr_low = wr_en & avs_byteenable_i[0];
  assign mapped = avs_address_i <= IDX_CORE_STATUS;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign avs_readdata_o    = readdata_reg;
  assign avs_response_o    = resp_reg;

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack_reg      <= 1'b0;
      readdata_reg <= '0;
      resp_reg     <= 2'b00;
    end
    else
    begin
      ack_reg  <= access;
      resp_reg <= (access & ~mapped) ? 2'b10 : 2'b00;
      if (access & avs_read_i)
      begin
        case (avs_address_i)
          IDX_IRQ_CONTROL:  readdata_reg <= DATA_W'(control_reg);
          IDX_FLAG_ONE:     readdata_reg <= widen(flag_one_reg);
          IDX_FLAG_TWO:     readdata_reg <= widen(flag_two_reg);
          IDX_FLAG_THREE:   readdata_reg <= widen(flag_three_reg);
          IDX_ENABLE_ONE:   readdata_reg <= widen(enable_one_reg);
          IDX_ENABLE_TWO:   readdata_reg <= widen(enable_two_reg);
          IDX_ENABLE_THREE: readdata_reg <= widen(enable_three_reg);
          IDX_OPTION:
            readdata_reg <= DATA_W'({edge_select_reg, 6'h00});
          IDX_CORE_STATUS:
            readdata_reg <= DATA_W'({wake_reg, state_reg, phase_reg});
          default:          readdata_reg <= '0;
        endcase
      end
    end
  end

  // instruction cycle phase counter, restarted by the core's cycle marker
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      phase_reg <= PHASE_ONE;
    else if (cycle_start_i)
      phase_reg <= PHASE_ONE;
    else
      phase_reg <= phase_reg + 2'h1;
  end
  assign phase_o = phase_reg;

  // pin edges are captured any time; flag updates from phase four to phase one
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ext_pending_reg <= 1'b0;
    else if (phase_reg == PHASE_FOUR || phase_reg == PHASE_ONE) // RULE_15
      ext_pending_reg <= 1'b0;
    else if (ext_edge)
      ext_pending_reg <= 1'b1;
  end

  // control register: enables are software, flags hardware-set
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      control_reg <= RST_CONTROL; // RULE_01 RULE_22
    else
    begin
      if (wr_low && avs_address_i == IDX_IRQ_CONTROL)
        control_reg[7:1] <= avs_writedata_i[7:1];
      if (entering)
        control_reg[BIT_GLOBAL_EN] <= 1'b0; // RULE_06
      else if (return_from_irq_i)
        control_reg[BIT_GLOBAL_EN] <= 1'b1; // RULE_10
      if (timer_event_i)
        control_reg[BIT_TIMER_FLAG] <= 1'b1; // RULE_04
      if ((ext_edge || ext_pending_reg)
          && (phase_reg == PHASE_FOUR || phase_reg == PHASE_ONE))
        control_reg[BIT_EXT_FLAG] <= 1'b1; // RULE_15 RULE_20
      // change flag mirrors its source summary, read only
      control_reg[BIT_CHANGE_FLAG] <= change_event_i;
    end
  end

  // peripheral flags, one bit per source
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      flag_one_reg   <= PERIPH_W'(RST_FLAGS);
      flag_two_reg   <= PERIPH_W'(RST_FLAGS);
      flag_three_reg <= PERIPH_W'(RST_FLAGS);
    end
    else
    begin
      flag_one_reg <= flag_next(flag_one_reg, periph_event_one_i, // RULE_05
        wr_low && avs_address_i == IDX_FLAG_ONE,
        avs_writedata_i[PERIPH_W-1:0]);
      flag_two_reg <= flag_next(flag_two_reg, periph_event_two_i, // RULE_04
        wr_low && avs_address_i == IDX_FLAG_TWO,
        avs_writedata_i[PERIPH_W-1:0]);
      flag_three_reg <= flag_next(flag_three_reg, periph_event_three_i,
        wr_low && avs_address_i == IDX_FLAG_THREE,
        avs_writedata_i[PERIPH_W-1:0]);
    end
  end

  // peripheral enables and edge select
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      enable_one_reg   <= PERIPH_W'(RST_ENABLES); // RULE_01
      enable_two_reg   <= PERIPH_W'(RST_ENABLES);
      enable_three_reg <= PERIPH_W'(RST_ENABLES);
      edge_select_reg  <= RST_EDGE;
    end
    else if (wr_low)
    begin
      case (avs_address_i)
        IDX_ENABLE_ONE:   enable_one_reg   <= avs_writedata_i[PERIPH_W-1:0];
        IDX_ENABLE_TWO:   enable_two_reg   <= avs_writedata_i[PERIPH_W-1:0];
        IDX_ENABLE_THREE: enable_three_reg <= avs_writedata_i[PERIPH_W-1:0];
        IDX_OPTION:       edge_select_reg  <= avs_writedata_i[BIT_EDGE_SELECT];
        default:          edge_select_reg  <= edge_select_reg;
      endcase
    end
  end

  // request tree
  assign periph_any = control_reg[BIT_GROUP_EN] // RULE_03
    & (|(flag_one_reg & enable_one_reg)
     | |(flag_two_reg & enable_two_reg)
     | |(flag_three_reg & enable_three_reg));
  assign core_any =
      (control_reg[BIT_TIMER_FLAG] & control_reg[BIT_TIMER_EN])
    | (control_reg[BIT_EXT_FLAG] & control_reg[BIT_EXT_EN])
    | (control_reg[BIT_CHANGE_FLAG] & control_reg[BIT_CHANGE_EN]); // RULE_02
  assign request = control_reg[BIT_GLOBAL_EN] // RULE_23 RULE_09
    & (core_any | periph_any);
  assign irq_request_o = request;

  // wake needs no global enable: individual enables, group enable for peripherals, and a clockless source
  assign wake_any = // RULE_16
      (control_reg[BIT_EXT_FLAG] & control_reg[BIT_EXT_EN])
    | (control_reg[BIT_CHANGE_FLAG] & control_reg[BIT_CHANGE_EN])
    | (control_reg[BIT_GROUP_EN]
       & (|(flag_one_reg & enable_one_reg & wake_capable_one_i)
        | |(flag_two_reg & enable_two_reg & wake_capable_two_i)
        | |(flag_three_reg & enable_three_reg & wake_capable_three_i)));

  // request sampled once per cycle at phase one
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      req_sampled_reg <= 1'b0;
    else if (phase_reg == PHASE_ONE)
      req_sampled_reg <= request; // RULE_14
  end

  assign entering = (state_reg == ST_RUN) && req_sampled_reg
    && request && phase_reg == PHASE_FOUR && !sleeping_i;

  // entry / wake sequencer; entry is independent of instruction length, wake waits for instr_done_i
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg     <= ST_RUN;
      entry_cnt_reg <= 2'h0;
      wake_reg      <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_RUN:
        begin
          wake_reg <= 1'b0;
          if (sleeping_i && wake_any)
          begin
            wake_reg  <= 1'b1;
            state_reg <= ST_WAKE;
          end
          else if (entering)
          begin
            entry_cnt_reg <= 2'h0;
            state_reg     <= ST_FLUSH; // RULE_11 RULE_12 RULE_13
          end
        end
        ST_WAKE:
        begin
          wake_reg <= 1'b0;
          if (instr_done_i)
            state_reg <= ST_RUN; // RULE_19 RULE_18
        end
        ST_FLUSH:
        begin
          if (phase_reg == PHASE_FOUR)
            state_reg <= ST_ENTRY;
        end
        ST_ENTRY:
        begin
          if (phase_reg == PHASE_FOUR)
          begin
            entry_cnt_reg <= entry_cnt_reg + 2'h1;
            if (entry_cnt_reg + 2'h1 >= ENTRY_CYCLES - 2'h1)
              state_reg <= ST_RUN;
          end
        end
        default:
          state_reg <= ST_RUN;
      endcase
    end
  end

  // core strobes, one clock each
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      flush_o          <= 1'b0;
      push_pc_o        <= 1'b0;
      shadow_save_o    <= 1'b0;
      load_vector_o    <= 1'b0;
      pop_pc_o         <= 1'b0;
      shadow_restore_o <= 1'b0;
      vector_o         <= IRQ_VECTOR;
      wake_o           <= 1'b0;
    end
    else
    begin
      flush_o       <= entering; // RULE_06
      push_pc_o     <= state_reg == ST_FLUSH && phase_reg == PHASE_FOUR;
      shadow_save_o <= state_reg == ST_FLUSH // RULE_21
        && phase_reg == PHASE_FOUR;
      load_vector_o <= state_reg == ST_ENTRY && phase_reg == PHASE_FOUR
        && entry_cnt_reg + 2'h1 >= ENTRY_CYCLES - 2'h1;
      pop_pc_o         <= return_from_irq_i; // RULE_10
      shadow_restore_o <= return_from_irq_i;
      vector_o         <= IRQ_VECTOR;
      wake_o           <= wake_reg; // RULE_18
    end
  end
endmodule
`default_nettype wire

// ===== test/cpu_interrupt_control_props.sv
// checker: port-level properties of the interrupt control block
`timescale 1ns/100ps
`default_nettype none
module cpu_interrupt_control_props
  (
    input wire logic        clk_sys_i,
    input wire logic        reset_n_i,
    input wire logic        sleeping_i,
    input wire logic        return_from_irq_i,
    input wire logic        irq_request_o,
    input wire logic        flush_o,
    input wire logic        push_pc_o,
    input wire logic        shadow_save_o,
    input wire logic        shadow_restore_o,
    input wire logic        pop_pc_o,
    input wire logic        load_vector_o,
    input wire logic [14:0] vector_o,
    input wire logic        wake_o
  );
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  a_reset_quiet:
  assert property ($rose(reset_n_i) |-> !irq_request_o ##1 !irq_request_o)
    else $error("request raised right after reset");
  a_vector_fixed:
  assert property (vector_o == 15'h0004)
    else $error("vector address wrong");
  a_entry_order:
  assert property (flush_o |-> !push_pc_o ##[1:8] push_pc_o)
    else $error("push did not follow flush");
  a_save_with_push:
  assert property (push_pc_o |-> shadow_save_o)
    else $error("context not shadowed with push");
  a_vector_load:
  assert property (push_pc_o |-> ##[1:4] load_vector_o)
    else $error("vector not loaded after push");
  a_return_pops:
  assert property (return_from_irq_i |=> pop_pc_o && shadow_restore_o)
    else $error("return did not pop and restore");
  a_entry_bound:
  assert property ($rose(irq_request_o) && !sleeping_i |-> ##[1:24] flush_o)
    else $error("entry too late after request");
  a_wake_asleep:
  assert property (wake_o |-> $past(sleeping_i))
    else $error("wake while not sleeping");
  a_global_cleared:
  assert property (load_vector_o |-> !irq_request_o)
    else $error("request still up at vector load");
endmodule
bind cpu_interrupt_control cpu_interrupt_control_props props
  (
    .clk_sys_i, .reset_n_i, .sleeping_i, .return_from_irq_i, .irq_request_o,
    .flush_o, .push_pc_o, .shadow_save_o, .shadow_restore_o, .pop_pc_o,
    .load_vector_o, .vector_o, .wake_o
  );
`default_nettype wire

// ===== test/core_seq_model.sv
// core sequencer model: cycle strobes, instruction ends, return strobes
`timescale 1ns/100ps
`default_nettype none
module core_seq_model
  (
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    input  wire logic two_cycle_i,
    input  wire logic hold_done_i,
    input  wire logic ret_req_i,
    output logic      cycle_start_o,
    output logic      instr_done_o,
    output logic      return_o
  );
  logic [1:0] cnt_reg;
  logic       odd_reg;
  logic       ret_reg;
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_reg <= 2'h0;
      odd_reg <= 1'b0;
      ret_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 2'h1;
      odd_reg <= odd_reg ^ (cnt_reg == 2'h3);
      ret_reg <= ret_req_i;
    end
  end
  assign cycle_start_o = (cnt_reg == 2'h3);
  // two-cycle mode ends an instruction every other cycle
  assign instr_done_o = cycle_start_o && !hold_done_i
                        && (!two_cycle_i || odd_reg);
  // one-clock return strobe per request
  assign return_o = ret_req_i && !ret_reg;
endmodule
`default_nettype wire

// ===== test/cpu_interrupt_control_bench.sv
// self-checking bench for the interrupt control block
`timescale 1ns/100ps
`default_nettype none
module cpu_interrupt_control_bench;
  import irq_ctrl_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [7:0]  pev [4] = '{default: 8'h00};
  logic [7:0]  wcap2 = 8'h00;
  logic        pin = 1'b0;
  logic        sleep = 1'b0;
  logic        two_cyc = 1'b0;
  logic        hold = 1'b0;
  logic        ret_req = 1'b0;
  logic [31:0] rdat, q;
  logic [1:0]  resp, rsp_q;
  logic [14:0] vec;
  logic        wait_r, cst, idone, retp, irq, flush, push, pop, ldv, wake;
  int          n_fail = 0;
  int          num_checks = 0;
  int          n_wake = 0;
  int          n_flush = 0;
  int          t, w0, f0;
  always #5 clk_sys_i = !clk_sys_i;
  always @(negedge clk_sys_i)
  begin
    n_wake += int'(wake === 1'b1);
    n_flush += int'(flush === 1'b1);
  end
  cpu_interrupt_control uut
    (
      .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .avs_address_i(adr),
      .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_byteenable_i(4'hf),
      .avs_writedata_i(wdat), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wait_r), .avs_response_o(resp),
      .ext_pin_i(pin), .timer_event_i(pev[0][0]),
      .change_event_i(pev[0][1]),
      .periph_event_one_i(pev[1]), .periph_event_two_i(pev[2]),
      .periph_event_three_i(pev[3]), .wake_capable_one_i(8'h00),
      .wake_capable_two_i(wcap2), .wake_capable_three_i(8'h00),
      .cycle_start_i(cst), .sleeping_i(sleep), .return_from_irq_i(retp),
      .instr_done_i(idone), .irq_request_o(irq), .flush_o(flush),
      .push_pc_o(push), .shadow_save_o(), .shadow_restore_o(),
      .pop_pc_o(pop), .load_vector_o(ldv), .vector_o(vec), .wake_o(wake),
      .phase_o()
    );
  core_seq_model core
    (
      .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .two_cycle_i(two_cyc),
      .hold_done_i(hold), .ret_req_i(ret_req), .cycle_start_o(cst),
      .instr_done_o(idone), .return_o(retp)
    );
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys_i);
    adr <= a;
    wdat <= d;
    wr_en <= w;
    rd_en <= !w;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_sys_i);
      if (wait_r === 1'b0)
        break;
    end
    q = rdat;
    rsp_q = resp;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    chk("waitrequest", 32'h0, 32'(wait_r));
    if (i == 20)
      results();
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e, m,
                      input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q & m);
  endtask
  task automatic fire(input int k, input logic [7:0] m);
    @(posedge clk_sys_i);
    pev[k] <= m;
    @(posedge clk_sys_i);
    pev[k] <= 8'h00;
  endtask
  task automatic await(ref logic s, input string nm);
    t = 0;
    while (s !== 1'b1 && t < 40)
    begin
      @(negedge clk_sys_i);
      t++;
    end
    chk(nm, 32'h1, 32'(s));
    if (t == 40)
      results();
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    for (int a = 0; a < 7; a++)
      rchk(4'(a), 32'h0, '1, "reset value");
    rchk(IDX_OPTION, 32'h40, 32'h40, "edge select");
    bus(1'b0, 4'h9, 32'h0);
    chk("unmapped resp", 32'h2, 32'(rsp_q));
    chk("unmapped data", 32'h0, q);
    $display("test reset done");
    for (int k = 1; k < 4; k++)
    begin
      fire(k, 8'h01 << k);
      rchk(4'(k), 32'h1 << k, '1, "periph flag");
    end
    fire(0, 8'h01);
    rchk(IDX_IRQ_CONTROL, 32'h04, '1, "timer flag");
    pev[0] <= 8'h02;
    rchk(IDX_IRQ_CONTROL, 32'h05, '1, "change flag");
    pev[0] <= 8'h00;
    chk("idle request", 32'h0, 32'(irq));
    $display("test flags done");
    bus(1'b1, IDX_ENABLE_ONE, 32'h02);
    bus(1'b1, IDX_IRQ_CONTROL, 32'h80);
    @(negedge clk_sys_i);
    chk("group off", 32'h0, 32'(irq));
    bus(1'b1, IDX_IRQ_CONTROL, 32'hc0);
    @(negedge clk_sys_i);
    chk("group on", 32'h1, 32'(irq));
    await(flush, "flush");
    await(push, "push");
    await(ldv, "vector load");
    chk("vector", 32'h4, 32'(vec));
    rchk(IDX_IRQ_CONTROL, 32'h40, '1, "global cleared");
    rchk(IDX_FLAG_ONE, 32'h02, '1, "poll flag");
    bus(1'b1, IDX_FLAG_ONE, 32'h0);
    ret();
    rchk(IDX_IRQ_CONTROL, 32'hc0, '1, "global restored");
    $display("test entry done");
    for (int m = 0; m < 2; m++)
    begin
      bus(1'b1, IDX_IRQ_CONTROL, 32'h60);
      two_cyc <= m[0];
      fire(0, 8'h01);
      @(negedge clk_sys_i);
      chk("held request", 32'h0, 32'(irq));
      bus(1'b1, IDX_IRQ_CONTROL, 32'he4);
      await(ldv, "late service");
      bus(1'b1, IDX_IRQ_CONTROL, 32'ha0);
      fire(0, 8'h01);
      await(ldv, "vector load");
      chk("latency", 32'h1, 32'(t >= 12 && t <= 16));
    end
    $display("test latency done");
    bus(1'b1, IDX_IRQ_CONTROL, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      if (s == 2)
        bus(1'b1, IDX_OPTION, 32'h0);
      @(posedge clk_sys_i);
      pin <= !pin;
      repeat (12) @(posedge clk_sys_i);
      rchk(IDX_IRQ_CONTROL, (s == 0 || s == 3) ? 32'h2 : 32'h0, '1,
           "pin flag");
      bus(1'b1, IDX_IRQ_CONTROL, 32'h0);
    end
    bus(1'b1, IDX_OPTION, 32'h40);
    bus(1'b1, IDX_IRQ_CONTROL, 32'h90);
    @(posedge clk_sys_i);
    pin <= 1'b1;
    await(ldv, "pin vector");
    chk("pin latency", 32'h1, 32'(t >= 12 && t <= 20));
    $display("test pin done");
    wcap2 <= 8'h01;
    bus(1'b1, IDX_ENABLE_TWO, 32'h03);
    for (int g = 0; g < 2; g++)
    begin
      bus(1'b1, IDX_FLAG_TWO, 32'h0);
      bus(1'b1, IDX_IRQ_CONTROL, g ? 32'hc0 : 32'h40);
      @(posedge clk_sys_i);
      sleep <= 1'b1;
      hold <= 1'b1;
      w0 = n_wake;
      fire(2, 8'h02);
      repeat (8) @(posedge clk_sys_i);
      chk("stray wake", 32'(w0), 32'(n_wake));
      f0 = n_flush;
      fire(2, 8'h01);
      await(wake, "wake");
      repeat (12) @(posedge clk_sys_i);
      chk("early flush", 32'(f0), 32'(n_flush));
      sleep <= 1'b0;
      hold <= 1'b0;
      if (g)
        await(flush, "wake vector");
      repeat (8) @(posedge clk_sys_i);
    end
    $display("test sleep done");
    results();
  end
  task automatic ret();
    @(posedge clk_sys_i);
    ret_req <= 1'b1;
    @(posedge clk_sys_i);
    ret_req <= 1'b0;
    await(pop, "pop");
  endtask
endmodule
`default_nettype wire
